//--- logic/opmc_pkg.sv
package opmc_pkg;

  typedef enum logic [1:0] {
    OPMC_SINGLE = 2'b00,
    OPMC_EXPANDED = 2'b01,
    OPMC_BOOT = 2'b10,
    OPMC_TEST = 2'b11
  } opmc_mode_e;

  typedef enum logic [1:0] {
    OPMC_ST_RESET = 2'b00,
    OPMC_ST_VECTOR = 2'b01,
    OPMC_ST_LOAD = 2'b10,
    OPMC_ST_RUN = 2'b11
  } opmc_boot_e;

  localparam logic [15:0] OPMC_BOOT_ROM_BASE = 16'hBF00;
  localparam logic [15:0] OPMC_BOOT_ROM_LAST = 16'hBFFF;
  localparam logic [15:0] OPMC_VECTOR_BASE = 16'hBFC0;
  localparam logic [15:0] OPMC_VECTOR_LAST = 16'hBFFF;
  localparam logic [15:0] OPMC_RAM_ENTRY = 16'h0000;
  localparam logic [15:0] OPMC_RAM_LAST = 16'h03FF;
  localparam int OPMC_LOAD_MAX_BYTES = 1024;
  localparam int OPMC_IDLE_CHARS = 4;
  localparam int OPMC_CHAR_BITS = 10;
  localparam int OPMC_CLK_HZ = 25000000;
  localparam int OPMC_BAUD_DEFAULT = 7812;
  localparam logic [7:0] OPMC_PORT_RESET = 8'h00;
  localparam logic [1:0] OPMC_MODE_RESET = 2'b00;

endpackage : opmc_pkg

//--- logic/opmc_top.sv
`timescale 1ns/1ps

// Summary of operation
// - The two mode-select levels are captured while reset is held and fix the mode for the run.
// - Four modes exist: single-chip and expanded, each with one special counterpart.
// - Single-chip mode drives no external bus and ports B, C and F stay general-purpose.
// - Expanded mode reaches a 64-Kbyte space of internal locations plus external devices.
// - Expanded mode puts the high address byte on port B, the low byte on port F, data on C.
// - Expanded mode drives the direction pin for port C and outside devices follow it.
// - Special test mode is expanded mode with privileged access to configuration and EEPROM.
// - Bootstrap mode is a single-chip variant that maps a small boot ROM.
// - Bootstrap mode takes its vectors from the boot ROM between BFC0 and BFFF until control passes to RAM.
// - After reset in bootstrap mode the reset vector is fetched and the loader runs.
// - The loader starts the serial interface and takes at most 1024 bytes into RAM.
// - Control passes to 0000 after a four-character idle gap or the byte for 03FF.
// - The loader sets port D to open-drain so the transmit pin needs a pull-up.
// - In bootstrap mode the interrupt vectors point into RAM once control has passed to 0000.
module opmc_top #(
  parameter logic [7:0] MODE_MAP = 8'hE4,
  parameter int BAUD = opmc_pkg::OPMC_BAUD_DEFAULT
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic mode_select_high,
  input wire logic mode_select_low,
  input wire logic [15:0] cpu_addr,
  input wire logic [7:0] cpu_wdata,
  input wire logic cpu_write,
  input wire logic cpu_access,
  input wire logic [7:0] gpio_b_out,
  input wire logic [7:0] gpio_c_out,
  input wire logic [7:0] gpio_c_oe,
  input wire logic [7:0] gpio_f_out,
  input wire logic [7:0] port_c_in,
  input wire logic rx_byte_valid,
  input wire logic loader_tx_active,
  output opmc_pkg::opmc_mode_e mode,
  output logic [7:0] port_b_out,
  output logic [7:0] port_f_out,
  output logic [7:0] port_c_out,
  output logic [7:0] port_c_oe,
  output logic [7:0] cpu_rdata_ext,
  output logic read_not_write,
  output logic bus_enable,
  output logic boot_rom_sel,
  output logic vector_from_rom,
  output logic vectors_to_ram,
  output logic privileged,
  output logic serial_enable,
  output logic port_d_open_drain,
  output logic loader_active,
  output logic [10:0] load_count,
  output logic jump_to_ram,
  output logic [15:0] jump_addr
);
  import opmc_pkg::*;

  localparam int CHAR_CYC = (OPMC_CLK_HZ + BAUD - 1) / BAUD * OPMC_CHAR_BITS;
  localparam int IDLE_CYC = CHAR_CYC * OPMC_IDLE_CHARS;
  localparam logic [23:0] IDLE_LIM = 24'(IDLE_CYC);

  function automatic opmc_mode_e decode_mode(input logic [1:0] sel);
    decode_mode = opmc_mode_e'(MODE_MAP[2 * sel +: 2]);
  endfunction : decode_mode

  function automatic logic in_range(input logic [15:0] a, input logic [15:0] lo,
                                    input logic [15:0] hi);
    in_range = (a >= lo) && (a <= hi);
  endfunction : in_range

  function automatic logic settle(input logic [2:0] sync, input logic prev);
    settle = (sync[1] == sync[2]) ? sync[2] : prev;
  endfunction : settle

  ////////////////////////////////////////////////////////////////////////////
  // Mode-select sampling.
  // Each select pin passes three flops; a level counts once the second and third agree.
  // The mode reloads while reset is seen and then holds until the next reset.
  logic [2:0] sel_hi_r;
  logic [2:0] sel_hi_nxt;
  logic [2:0] sel_lo_r;
  logic [2:0] sel_lo_nxt;
  logic [1:0] pair_r;
  logic [1:0] pair_nxt;
  logic rst_d_r;
  logic rst_d_nxt;
  opmc_mode_e mode_r;
  opmc_mode_e mode_nxt;

  always_comb begin
    sel_hi_nxt = {sel_hi_r[1:0], mode_select_high};
    sel_lo_nxt = {sel_lo_r[1:0], mode_select_low};
    pair_nxt[1] = settle(sel_hi_r, pair_r[1]);
    pair_nxt[0] = settle(sel_lo_r, pair_r[0]);
    rst_d_nxt = sys_rst;
    mode_nxt = mode_r;
    if (rst_d_r) begin
      mode_nxt = decode_mode(pair_r);
    end
  end

  always_ff @(posedge core_clk) begin
    sel_hi_r <= sel_hi_nxt;
    sel_lo_r <= sel_lo_nxt;
    pair_r <= pair_nxt;
    rst_d_r <= rst_d_nxt;
    mode_r <= mode_nxt;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bootstrap loader sequencing.
  // The loader waits for the vector fetch, counts bytes, then jumps on the last byte or a gap.
  // Bytes past the limit are ignored and the idle timer holds while the transmitter is busy.
  opmc_boot_e boot_r;
  opmc_boot_e boot_nxt;
  logic [10:0] cnt_r;
  logic [10:0] cnt_nxt;
  logic [23:0] idle_r;
  logic [23:0] idle_nxt;
  logic [23:0] idle_inc;
  logic jump_r;
  logic jump_nxt;
  logic is_boot;

  always_comb begin
    is_boot = (mode_r == OPMC_BOOT);
    boot_nxt = boot_r;
    cnt_nxt = cnt_r;
    idle_nxt = idle_r;
    jump_nxt = 1'b0;
    idle_inc = idle_r + 24'h000001;
    case (boot_r)
      OPMC_ST_RESET: begin
        if (!rst_d_r && is_boot) begin
          boot_nxt = OPMC_ST_VECTOR;
        end else if (!rst_d_r) begin
          boot_nxt = OPMC_ST_RUN;
        end
      end
      OPMC_ST_VECTOR: begin
        if (cpu_access && !cpu_write && in_range(cpu_addr, OPMC_VECTOR_BASE,
                                                 OPMC_VECTOR_LAST)) begin
          boot_nxt = OPMC_ST_LOAD;
          cnt_nxt = 11'h000;
          idle_nxt = 24'h000000;
        end
      end
      OPMC_ST_LOAD: begin
        if (rx_byte_valid && cnt_r < 11'(OPMC_LOAD_MAX_BYTES)) begin
          cnt_nxt = cnt_r + 11'h001;
          idle_nxt = 24'h000000;
          if (cnt_r == 11'(OPMC_RAM_LAST)) begin
            boot_nxt = OPMC_ST_RUN;
            jump_nxt = 1'b1;
          end
        end else if (cnt_r != 11'h000 && !loader_tx_active) begin
          idle_nxt = idle_inc;
          if (idle_inc >= IDLE_LIM) begin
            boot_nxt = OPMC_ST_RUN;
            jump_nxt = 1'b1;
          end
        end
      end
      OPMC_ST_RUN: begin
        boot_nxt = OPMC_ST_RUN;
      end
      default: begin
        boot_nxt = OPMC_ST_RESET;
      end
    endcase
    if (sys_rst) begin
      boot_nxt = OPMC_ST_RESET;
      cnt_nxt = 11'h000;
      idle_nxt = 24'h000000;
      jump_nxt = 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    boot_r <= boot_nxt;
    cnt_r <= cnt_nxt;
    idle_r <= idle_nxt;
    jump_r <= jump_nxt;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Port muxing and output registers.
  // Ports B, F and C carry the bus only in expanded and test modes, else the GPIO values.
  logic exp_r;
  logic exp_nxt;
  logic [7:0] pb_r;
  logic [7:0] pb_nxt;
  logic [7:0] pf_r;
  logic [7:0] pf_nxt;
  logic [7:0] pc_r;
  logic [7:0] pc_nxt;
  logic [7:0] pcoe_r;
  logic [7:0] pcoe_nxt;
  logic [7:0] rd_r;
  logic [7:0] rd_nxt;
  logic rnw_r;
  logic rnw_nxt;
  logic rom_r;
  logic rom_nxt;
  logic vrom_r;
  logic vrom_nxt;
  logic vram_r;
  logic vram_nxt;
  logic priv_r;
  logic priv_nxt;
  logic ser_r;
  logic ser_nxt;
  logic od_r;
  logic od_nxt;
  logic ld_r;
  logic ld_nxt;
  logic [15:0] jaddr_r;
  logic [15:0] jaddr_nxt;

  always_comb begin
    exp_nxt = (mode_r == OPMC_EXPANDED) || (mode_r == OPMC_TEST);
    priv_nxt = (mode_r == OPMC_TEST);
    jaddr_nxt = OPMC_RAM_ENTRY;
    if (exp_r) begin
      pb_nxt = cpu_addr[15:8];
      pf_nxt = cpu_addr[7:0];
      rnw_nxt = !(cpu_access && cpu_write);
      pc_nxt = cpu_wdata;
      pcoe_nxt = (cpu_access && cpu_write) ? 8'hFF : 8'h00;
    end else begin
      pb_nxt = gpio_b_out;
      pf_nxt = gpio_f_out;
      rnw_nxt = 1'b1;
      pc_nxt = gpio_c_out;
      pcoe_nxt = gpio_c_oe;
    end
    rd_nxt = port_c_in;
    rom_nxt = is_boot && cpu_access && in_range(cpu_addr, OPMC_BOOT_ROM_BASE,
                                                OPMC_BOOT_ROM_LAST);
    vrom_nxt = is_boot && (boot_r != OPMC_ST_RUN);
    vram_nxt = is_boot && (boot_r == OPMC_ST_RUN);
    ld_nxt = is_boot && (boot_r == OPMC_ST_LOAD);
    ser_nxt = ld_nxt;
    od_nxt = ld_nxt || vram_nxt;
    if (sys_rst) begin
      exp_nxt = 1'b0;
      priv_nxt = 1'b0;
      pb_nxt = OPMC_PORT_RESET;
      pf_nxt = OPMC_PORT_RESET;
      pc_nxt = OPMC_PORT_RESET;
      pcoe_nxt = OPMC_PORT_RESET;
      rnw_nxt = 1'b1;
      rom_nxt = 1'b0;
      vrom_nxt = 1'b0;
      vram_nxt = 1'b0;
      ld_nxt = 1'b0;
      ser_nxt = 1'b0;
      od_nxt = 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    exp_r <= exp_nxt;
    priv_r <= priv_nxt;
    pb_r <= pb_nxt;
    pf_r <= pf_nxt;
    pc_r <= pc_nxt;
    pcoe_r <= pcoe_nxt;
    rd_r <= rd_nxt;
    rnw_r <= rnw_nxt;
    rom_r <= rom_nxt;
    vrom_r <= vrom_nxt;
    vram_r <= vram_nxt;
    ld_r <= ld_nxt;
    ser_r <= ser_nxt;
    od_r <= od_nxt;
    jaddr_r <= jaddr_nxt;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Every output comes straight from a register.

  assign mode = mode_r;
  assign port_b_out = pb_r;
  assign port_f_out = pf_r;
  assign port_c_out = pc_r;
  assign port_c_oe = pcoe_r;
  assign cpu_rdata_ext = rd_r;
  assign read_not_write = rnw_r;
  assign bus_enable = exp_r;
  assign boot_rom_sel = rom_r;
  assign vector_from_rom = vrom_r;
  assign vectors_to_ram = vram_r;
  assign privileged = priv_r;
  assign serial_enable = ser_r;
  assign port_d_open_drain = od_r;
  assign loader_active = ld_r;
  assign load_count = cnt_r;
  assign jump_to_ram = jump_r;
  assign jump_addr = jaddr_r;

endmodule : opmc_top

//--- verification/opmc_monitor.sv
`timescale 1ns/1ps
module opmc_monitor (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic [15:0] cpu_addr,
  input wire logic cpu_write,
  input wire logic cpu_access,
  input opmc_pkg::opmc_mode_e mode,
  input wire logic [7:0] port_b_out,
  input wire logic [7:0] port_f_out,
  input wire logic read_not_write,
  input wire logic bus_enable,
  input wire logic boot_rom_sel,
  input wire logic vectors_to_ram,
  input wire logic privileged,
  input wire logic serial_enable,
  input wire logic loader_active,
  input wire logic [10:0] load_count,
  input wire logic jump_to_ram,
  input wire logic [15:0] jump_addr
);
  import opmc_pkg::*;
  logic [2:0] run_r;
  logic [2:0] run_nxt;
  logic ok;
  always_comb run_nxt = sys_rst ? 3'h0 : (run_r == 3'h7 ? run_r : run_r + 3'h1);
  always_ff @(posedge core_clk) run_r <= run_nxt;
  assign ok = (run_r >= 3'h2);
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  AST_MODE_HOLD: assert property (ok |-> $stable(mode))
    else $error("mode changed during run");
  AST_BUS_EN: assert property (ok |-> bus_enable == (mode inside {OPMC_EXPANDED, OPMC_TEST}))
    else $error("bus enable does not follow mode");
  AST_PRIV: assert property (ok |-> privileged == (mode == OPMC_TEST))
    else $error("privileged does not follow mode");
  AST_NO_BUS: assert property (ok && mode == OPMC_SINGLE |-> !bus_enable && !boot_rom_sel)
    else $error("bus active in single-chip mode");
  AST_ADDR: assert property (ok && bus_enable && cpu_access |=>
    port_b_out == $past(cpu_addr[15:8]) && port_f_out == $past(cpu_addr[7:0]))
    else $error("address bytes wrong");
  AST_DIR: assert property (ok && bus_enable && cpu_access |=> read_not_write == !$past(cpu_write))
    else $error("direction pin wrong");
  AST_ROM: assert property (ok && mode == OPMC_BOOT && cpu_access && cpu_addr[15:8] == 8'hBF
    |=> boot_rom_sel) else $error("boot rom not selected");
  AST_JUMP: assert property (jump_to_ram |-> mode == OPMC_BOOT && jump_addr == 16'h0000
    ##1 !jump_to_ram && vectors_to_ram) else $error("jump pulse wrong");
  AST_MAX: assert property (load_count <= 11'h400)
    else $error("load count above limit");
  AST_LOADER: assert property (loader_active |-> serial_enable && mode == OPMC_BOOT)
    else $error("loader active outside boot");
  cover property (jump_to_ram);
  cover property (bus_enable && cpu_access && cpu_write);
  cover property (boot_rom_sel);
endmodule : opmc_monitor
bind opmc_top opmc_monitor mon_u (
  .core_clk(core_clk),
  .sys_rst(sys_rst),
  .cpu_addr(cpu_addr),
  .cpu_write(cpu_write),
  .cpu_access(cpu_access),
  .mode(mode),
  .port_b_out(port_b_out),
  .port_f_out(port_f_out),
  .read_not_write(read_not_write),
  .bus_enable(bus_enable),
  .boot_rom_sel(boot_rom_sel),
  .vectors_to_ram(vectors_to_ram),
  .privileged(privileged),
  .serial_enable(serial_enable),
  .loader_active(loader_active),
  .load_count(load_count),
  .jump_to_ram(jump_to_ram),
  .jump_addr(jump_addr)
);

//--- verification/opmc_bus_partner.sv
`timescale 1ns/1ps
module opmc_bus_partner (
  input wire logic core_clk,
  input wire logic [7:0] port_b_out,
  input wire logic [7:0] port_f_out,
  input wire logic read_not_write,
  input wire logic bus_enable,
  output logic [7:0] port_c_in
);
  logic [7:0] last_r = 8'h00;
  always_ff @(posedge core_clk) last_r <= port_c_in;
  // Memory answers reads from the address; a released bus toggles every cycle.
  assign port_c_in = (bus_enable && read_not_write) ?
    (port_b_out ^ port_f_out ^ 8'h5A) : ~last_r;
endmodule : opmc_bus_partner

//--- verification/opmc_top_tb.sv
`timescale 1ns/1ps
module opmc_top_tb;
  import opmc_pkg::*;
  localparam logic [7:0] MAP = 8'hE4;
  logic core_clk, sys_rst, mode_select_high, mode_select_low, cpu_write, cpu_access;
  logic rx_byte_valid, loader_tx_active, read_not_write, bus_enable, boot_rom_sel;
  logic vector_from_rom, vectors_to_ram, privileged, serial_enable, port_d_open_drain;
  logic loader_active, jump_to_ram;
  logic [15:0] cpu_addr, jump_addr;
  logic [7:0] cpu_wdata, gpio_b_out, gpio_c_out, gpio_c_oe, gpio_f_out, port_c_in;
  logic [7:0] port_b_out, port_f_out, port_c_out, port_c_oe, cpu_rdata_ext;
  logic [10:0] load_count;
  opmc_mode_e mode;
  int n_mismatch = 0;
  int checked = 0;
  int cyc = 0;
  int n;
  opmc_top #(.MODE_MAP(MAP), .BAUD(25000000)) dut_u (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .mode_select_high(mode_select_high),
    .mode_select_low(mode_select_low),
    .cpu_addr(cpu_addr),
    .cpu_wdata(cpu_wdata),
    .cpu_write(cpu_write),
    .cpu_access(cpu_access),
    .gpio_b_out(gpio_b_out),
    .gpio_c_out(gpio_c_out),
    .gpio_c_oe(gpio_c_oe),
    .gpio_f_out(gpio_f_out),
    .port_c_in(port_c_in),
    .rx_byte_valid(rx_byte_valid),
    .loader_tx_active(loader_tx_active),
    .mode(mode),
    .port_b_out(port_b_out),
    .port_f_out(port_f_out),
    .port_c_out(port_c_out),
    .port_c_oe(port_c_oe),
    .cpu_rdata_ext(cpu_rdata_ext),
    .read_not_write(read_not_write),
    .bus_enable(bus_enable),
    .boot_rom_sel(boot_rom_sel),
    .vector_from_rom(vector_from_rom),
    .vectors_to_ram(vectors_to_ram),
    .privileged(privileged),
    .serial_enable(serial_enable),
    .port_d_open_drain(port_d_open_drain),
    .loader_active(loader_active),
    .load_count(load_count),
    .jump_to_ram(jump_to_ram),
    .jump_addr(jump_addr)
  );
  opmc_bus_partner bus_u (
    .core_clk(core_clk),
    .port_b_out(port_b_out),
    .port_f_out(port_f_out),
    .read_not_write(read_not_write),
    .bus_enable(bus_enable),
    .port_c_in(port_c_in)
  );
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_mismatch++;
      stop_test();
    end
  end
  task automatic tick(input int k);
    repeat (k) @(posedge core_clk);
    #1;
  endtask : tick
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      n_mismatch++;
    end
  endtask : check
  task automatic stop_test();
    $display("mismatches %0d checks %0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : stop_test
  task automatic boot(input logic [1:0] sel);
    {mode_select_high, mode_select_low} = sel;
    sys_rst = 1'b1;
    tick(8);
    sys_rst = 1'b0;
    tick(2);
    check(mode, MAP[2*int'(sel)+:2]);
  endtask : boot
  task automatic bus_cycle(input logic wr, input logic [15:0] a, input logic [7:0] d);
    {cpu_access, cpu_write, cpu_addr, cpu_wdata} = {1'b1, wr, a, d};
    tick(1);
    cpu_access = 1'b0;
    check({port_b_out, port_f_out}, a);
    check(read_not_write, !wr);
    if (wr) check({port_c_oe, port_c_out}, {8'hFF, d});
    else begin
      tick(1);
      check(cpu_rdata_ext, a[15:8] ^ a[7:0] ^ 8'h5A);
    end
  endtask : bus_cycle
  task automatic enter_loader();
    boot(2'b10);
    check({bus_enable, vector_from_rom, vectors_to_ram}, 3'b010);
    {cpu_access, cpu_addr} = {1'b1, 16'hBFC0};
    tick(1);
    cpu_access = 1'b0;
    check(boot_rom_sel, 1'b1);
    tick(2);
    check({loader_active, serial_enable, port_d_open_drain}, 3'b111);
  endtask : enter_loader
  task automatic wait_jump();
    n = 0;
    while (jump_to_ram !== 1'b1 && n < 600) begin
      tick(1);
      n++;
    end
  endtask : wait_jump
  task automatic t_single();
    boot(2'b00);
    {gpio_b_out, gpio_f_out, gpio_c_oe, gpio_c_out} = 32'h3CC30F96;
    {cpu_access, cpu_addr} = {1'b1, 16'h1234};
    tick(2);
    cpu_access = 1'b0;
    check({bus_enable, privileged, boot_rom_sel}, 3'b000);
    check({port_b_out, port_f_out}, 16'h3CC3);
    check({port_c_oe, port_c_out}, 16'h0F96);
  endtask : t_single
  task automatic t_expanded();
    boot(2'b01);
    check(bus_enable, 1'b1);
    bus_cycle(1'b0, 16'h1234, 8'h00);
    bus_cycle(1'b1, 16'hFE01, 8'hA5);
  endtask : t_expanded
  task automatic t_test();
    boot(2'b11);
    check({bus_enable, privileged}, 2'b11);
    bus_cycle(1'b0, 16'h0F00, 8'h00);
  endtask : t_test
  task automatic t_boot_full();
    enter_loader();
    rx_byte_valid = 1'b1;
    tick(1024);
    rx_byte_valid = 1'b0;
    wait_jump();
    check(n <= 1, 1'b1);
    check(jump_addr, 16'h0000);
    check(load_count, 11'h400);
    tick(1);
    check({jump_to_ram, vectors_to_ram, vector_from_rom, loader_active}, 4'b0100);
    rx_byte_valid = 1'b1;
    tick(3);
    rx_byte_valid = 1'b0;
    check(load_count, 11'h400);
    {cpu_access, cpu_addr} = {1'b1, 16'hBF80};
    tick(1);
    check(boot_rom_sel, 1'b1);
    cpu_addr = 16'hBEFF;
    tick(1);
    cpu_access = 1'b0;
    check(boot_rom_sel, 1'b0);
  endtask : t_boot_full
  task automatic t_boot_idle();
    enter_loader();
    rx_byte_valid = 1'b1;
    tick(3);
    {rx_byte_valid, loader_tx_active} = 2'b01;
    tick(10);
    loader_tx_active = 1'b0;
    wait_jump();
    check(n == OPMC_IDLE_CHARS * OPMC_CHAR_BITS, 1'b1);
    check(load_count, 11'h003);
  endtask : t_boot_idle
  initial begin
    {sys_rst, mode_select_high, mode_select_low, cpu_write, cpu_access} = 5'b10000;
    {cpu_addr, cpu_wdata, gpio_b_out, gpio_c_out, gpio_c_oe, gpio_f_out} = '0;
    {rx_byte_valid, loader_tx_active} = 2'b00;
    t_single();
    t_expanded();
    t_test();
    t_boot_full();
    t_boot_idle();
    stop_test();
  end
endmodule : opmc_top_tb
